/* File: nand_status_pkg.sv */
// Purpose: shared constants and types for the serial flash status register block
// Assumes: a 50 MHz system clock sampling the serial pins
// Notes: status byte layout is carried by status_t, most significant field first
package nand_status_pkg;

   localparam logic [7:0] OPC_GET_FEAT = 8'h0f;
   localparam logic [7:0] OPC_SET_FEAT = 8'h1f;
   localparam logic [7:0] OPC_WR_EN = 8'h06;
   localparam logic [7:0] OPC_WR_DIS = 8'h04;
   localparam logic [7:0] OPC_PROG_EXEC = 8'h10;
   localparam logic [7:0] OPC_PAGE_READ = 8'h13;
   localparam logic [7:0] OPC_BLOCK_ERASE = 8'hd8;
   localparam logic [7:0] OPC_RESET = 8'hff;

   localparam logic [7:0] ADDR_OPERATION_STATUS = 8'hc0;
   localparam logic [7:0] ADDR_OUTPUT_DRIVE = 8'hd0;

   // byte positions inside a frame
   localparam logic [2:0] BYTE_OPCODE = 3'h0;
   localparam logic [2:0] BYTE_ADDR = 3'h1;
   localparam logic [2:0] BYTE_DATA = 3'h2;
   localparam logic [2:0] BYTE_ROW_HI = 3'h2;
   localparam logic [2:0] BYTE_ROW_LO = 3'h3;
   localparam logic [2:0] BYTE_ROW_DONE = 3'h4;
   localparam logic [2:0] BYTE_LAST = 3'h7;

   // ecc_result_field codes, {upper two, lower two}, then the error-count limits ECC_CAPABILITY and ECC_LOW_LIMIT
   localparam logic [3:0] ECC_NONE = 4'h0;
   localparam logic [3:0] ECC_UPTO4 = 4'h1;
   localparam logic [3:0] ECC_FIVE = 4'h5;
   localparam logic [3:0] ECC_SIX = 4'h9;
   localparam logic [3:0] ECC_SEVEN = 4'hd;
   localparam logic [3:0] ECC_UNCORR = 4'h2;
   localparam logic [3:0] ECC_AT_LIMIT = 4'h3;
   localparam logic [3:0] ECC_CAPABILITY = 4'h8;
   localparam logic [3:0] ECC_LOW_LIMIT = 4'h4;

   localparam logic [7:0] DRIVE_RESET = 8'h00;

   localparam int CLK_PERIOD_NS = 20;
   localparam int RESET_BUSY_NS = 5000;
   localparam int RESET_BUSY_CYCLES = (RESET_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_CNT_W = $clog2(RESET_BUSY_CYCLES + 1);

   typedef enum logic [1:0] {ARR_READ = 2'h0, ARR_PROG = 2'h1, ARR_ERASE = 2'h2} array_op_t;
   typedef enum logic [3:0] {ST_BOOT = 4'b0001, ST_IDLE = 4'b0010, ST_RUN = 4'b0100, ST_RESET = 4'b1000} op_state_t;

   typedef struct packed {
      logic [3:0] ecc_result_field;
      logic pfail;
      logic efail;
      logic write_permit_latch;
      logic operation_busy_flag;
   } status_t;

   localparam status_t STATUS_RESET = '{ecc_result_field: ECC_NONE, pfail: 1'b0, efail: 1'b0,
                                        write_permit_latch: 1'b0, operation_busy_flag: 1'b1};

   typedef struct packed {
      logic [3:0] err_count;
      logic uncorr;
   } ecc_report_t;

   typedef struct packed {
      logic done;
      logic fail;
      ecc_report_t ecc;
   } array_result_t;

   typedef struct packed {
      logic req;
      logic abort;
      array_op_t op;
      logic [15:0] row;
   } array_cmd_t;

endpackage

/* File: pin_sync.sv */
// Purpose: two-flop synchroniser with edge pulses for asynchronous pins
// Assumes: pins are slow against the sampling clock
// Notes: edges are taken from the second and third flops only
module pin_sync
   import nand_status_pkg::*;
#(
   parameter int W = 3,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_level,
   output logic [W-1:0] o_rise,
   output logic [W-1:0] o_fall
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } sync_t;

   sync_t q, d;

   always_comb begin
      d = q;
      d.s1 = i_async;
      d.s2 = q.s1;
      d.s3 = q.s2;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL};
      end else begin
         q <= d;
      end
   end

   assign o_level = q.s2;
   assign o_rise = q.s2 & ~q.s3;
   assign o_fall = ~q.s2 & q.s3;
endmodule // pin_sync

/* File: ecc_result_encoder.sv */
// Purpose: map a corrected-error count to the four-bit ecc result code
// Assumes: the count saturates at the correction capability of 8
// Notes: purely combinational
module ecc_result_encoder
   import nand_status_pkg::*;
(
   input wire ecc_report_t i_report,
   output logic [3:0] o_field
);
   always_comb begin
      if (i_report.uncorr) begin
         o_field = ECC_UNCORR; // see RULE_05
      end else if (i_report.err_count == 4'h0) begin
         o_field = ECC_NONE; // see RULE_03
      end else if (i_report.err_count <= ECC_LOW_LIMIT) begin
         o_field = ECC_UPTO4; // see RULE_04
      end else if (i_report.err_count == 4'h5) begin
         o_field = ECC_FIVE; // see RULE_04
      end else if (i_report.err_count == 4'h6) begin
         o_field = ECC_SIX; // see RULE_04
      end else if (i_report.err_count == 4'h7) begin
         o_field = ECC_SEVEN; // see RULE_04
      end else begin
         // counts at or above capability but still corrected
         o_field = ECC_AT_LIMIT; // see RULE_06
      end
   end
endmodule // ecc_result_encoder

/* File: nand_status_register.sv */
// Purpose: status and drive-strength feature registers of a serial flash, with their serial access
// Assumes: host clocks the link in mode 0, far slower than I_SYS_CLK; array engine sits outside
// Notes: commands act as chip select rises at frame end, except get-features, which replies in frame, and set-features, which writes drive strength mid-frame
// Notes on behaviour
// RULE_01: status byte is returned by get-features at status feature address.
// RULE_02: drive strength register written by set-features, read by get-features.
// RULE_03: ecc code with low bits 00 means the last read saw no errors.
// RULE_04: low bits 01 with upper bits giving four-or-less, five, six or seven corrected.
// RULE_05: low bits 10 report errors beyond capability, data left uncorrected.
// RULE_06: low bits 11 report errors exactly at capability, still corrected.
// RULE_07: host should refresh a block whose read reports the at-limit code.
// RULE_08: ecc code cleared on reset command and read start, set after read.
// RULE_09: after power-on the ecc code shows the read of block 0 page 0.
// RULE_10: program failure flag is set when an array program fails.
// RULE_11: program failure flag also set for invalid or protected target rows.
// RULE_12: program failure flag cleared by program-execute and by reset command.
// RULE_13: erase failure flag set on failed erase or erase of locked region.
// RULE_14: erase failure flag cleared at block-erase start and by reset command.
// RULE_15: host must see the write permit latch set before program or erase.
// RULE_16: write-enable sets the latch, write-disable clears it, status shows it.
// RULE_17: busy flag is high during program, page read, erase and reset.
// RULE_18: program or erase of a locked row keeps busy low and sets failure.
// RULE_19: an erase without a prior write-enable is ignored.
// RULE_20: status bits: busy 0, latch 1, erase fail 2, program fail 3, ecc 7:4.
// RULE_21: status reads are served while busy without disturbing the operation.
module nand_status_register
   import nand_status_pkg::*;
(
   input wire logic I_SYS_CLK,
   input wire logic I_RST,
   input wire logic I_SCK,
   input wire logic I_CS_N,
   input wire logic I_SI,
   output logic O_SO,
   output logic O_SO_OE,
   input wire array_result_t I_ARRAY_RESULT,
   input wire logic I_ROW_PROTECTED,
   output array_cmd_t O_ARRAY_CMD,
   output status_t O_STATUS,
   output logic [7:0] O_DRIVE_STRENGTH
);
   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [2:0] byte_cnt;
      logic [7:0] shreg;
      logic [7:0] opcode;
      logic [7:0] feat_addr;
      logic [7:0] tx;
      logic so;
      logic so_oe;
      op_state_t st;
      logic issued;
      logic [RESET_CNT_W-1:0] wait_cnt;
      status_t stat;
      logic [7:0] drive;
      array_cmd_t cmd;
   } state_t;

   localparam state_t STATE_RST = '{
      bit_cnt: 3'h0, byte_cnt: 3'h0, shreg: 8'h00, opcode: 8'h00, feat_addr: 8'h00, tx: 8'h00,
      so: 1'b0, so_oe: 1'b0, st: ST_BOOT, issued: 1'b0, wait_cnt: '0, stat: STATUS_RESET,
      drive: DRIVE_RESET, cmd: '{req: 1'b0, abort: 1'b0, op: ARR_READ, row: 16'h0000}};

   state_t q, d;
   logic [2:0] pin_lvl, pin_rise, pin_fall;
   logic cs_n_lvl, cs_rise, cs_fall, sck_rise, sck_fall, si_lvl;
   logic [3:0] ecc_code;

   pin_sync #(.W(3), .RESET_VAL(3'h4)) u_pin_sync (
      .i_clk(I_SYS_CLK),
      .i_rst(I_RST),
      .i_async({I_CS_N, I_SCK, I_SI}),
      .o_level(pin_lvl),
      .o_rise(pin_rise),
      .o_fall(pin_fall)
   );

   ecc_result_encoder u_ecc_enc (
      .i_report(I_ARRAY_RESULT.ecc),
      .o_field(ecc_code)
   );

   assign cs_n_lvl = pin_lvl[2];
   assign cs_rise = pin_rise[2];
   assign cs_fall = pin_fall[2];
   assign sck_rise = pin_rise[1];
   assign sck_fall = pin_fall[1];
   assign si_lvl = pin_lvl[0];

   function automatic logic is_array_op(input logic [7:0] opc);
      return (opc == OPC_PROG_EXEC) || (opc == OPC_PAGE_READ) || (opc == OPC_BLOCK_ERASE);
   endfunction

   always_comb begin
      logic [7:0] rx;
      logic [7:0] addr;
      rx = {q.shreg[6:0], si_lvl};
      addr = q.feat_addr;
      d = q;
      d.cmd.req = 1'b0;
      d.cmd.abort = 1'b0;

      // ---- serial framing ----
      if (cs_fall) begin
         d.bit_cnt = 3'h0;
         d.byte_cnt = 3'h0;
      end
      if (!cs_n_lvl && sck_rise) begin
         d.shreg = rx;
         d.bit_cnt = 3'(q.bit_cnt + 3'h1);
         if (q.bit_cnt == 3'h7) begin
            if (q.byte_cnt != BYTE_LAST) begin
               d.byte_cnt = 3'(q.byte_cnt + 3'h1);
            end
            if (q.byte_cnt == BYTE_OPCODE) begin
               d.opcode = rx;
               if (is_array_op(rx) && q.st == ST_IDLE) begin
                  // op shows early so the outside protection check can judge the row
                  d.cmd.op = (rx == OPC_PAGE_READ) ? ARR_READ : (rx == OPC_PROG_EXEC) ? ARR_PROG : ARR_ERASE;
               end
            end else if (q.opcode == OPC_GET_FEAT) begin
               if (q.byte_cnt == BYTE_ADDR) begin
                  d.feat_addr = rx;
                  addr = rx;
               end
               // reload each byte so polling keeps returning live status, busy or not
               if (addr == ADDR_OPERATION_STATUS) begin
                  d.tx = q.stat; // see RULE_01, RULE_21
               end else if (addr == ADDR_OUTPUT_DRIVE) begin
                  d.tx = q.drive; // see RULE_02
               end else begin
                  d.tx = 8'h00;
               end
            end else if (q.opcode == OPC_SET_FEAT) begin
               if (q.byte_cnt == BYTE_ADDR) begin
                  d.feat_addr = rx;
               end else if (q.byte_cnt == BYTE_DATA && q.feat_addr == ADDR_OUTPUT_DRIVE && q.st == ST_IDLE) begin
                  d.drive = rx; // see RULE_02
               end
            end else if (is_array_op(q.opcode) && q.st == ST_IDLE) begin
               if (q.byte_cnt == BYTE_ROW_HI) begin
                  d.cmd.row[15:8] = rx;
               end else if (q.byte_cnt == BYTE_ROW_LO) begin
                  d.cmd.row[7:0] = rx;
               end
            end
         end
      end
      // reply bits change on the falling edge so they are settled for the host's rising edge
      if (!cs_n_lvl && sck_fall && q.opcode == OPC_GET_FEAT && q.byte_cnt >= BYTE_DATA) begin
         d.so = q.tx[7]; // see RULE_01
         d.tx = {q.tx[6:0], 1'b0};
         d.so_oe = 1'b1;
      end
      if (cs_rise) begin
         d.so_oe = 1'b0;
      end

      // ---- operation sequencing ----
      unique case (q.st)
         ST_BOOT: begin
            if (!q.issued) begin
               d.cmd.req = 1'b1;
               d.cmd.op = ARR_READ;
               d.cmd.row = 16'h0000;
               d.issued = 1'b1;
            end else if (I_ARRAY_RESULT.done) begin
               d.stat.ecc_result_field = ecc_code; // see RULE_09
               d.stat.operation_busy_flag = 1'b0;
               d.st = ST_IDLE;
            end
         end
         ST_RUN: begin
            if (I_ARRAY_RESULT.done) begin
               d.stat.operation_busy_flag = 1'b0; // see RULE_17
               d.st = ST_IDLE;
               unique case (q.cmd.op)
                  ARR_READ: d.stat.ecc_result_field = ecc_code; // see RULE_03, RULE_08
                  ARR_PROG: begin
                     d.stat.pfail = I_ARRAY_RESULT.fail; // see RULE_10
                     d.stat.write_permit_latch = 1'b0;
                  end
                  default: begin
                     d.stat.efail = I_ARRAY_RESULT.fail; // see RULE_13
                     d.stat.write_permit_latch = 1'b0;
                  end
               endcase
            end
         end
         ST_RESET: begin
            if (q.wait_cnt == '0) begin
               d.stat.operation_busy_flag = 1'b0;
               d.st = ST_IDLE;
            end else begin
               d.wait_cnt = RESET_CNT_W'(q.wait_cnt - 1'b1);
            end
         end
         ST_IDLE: begin
            if (cs_rise && q.byte_cnt >= BYTE_ADDR && q.opcode == OPC_WR_EN) begin
               d.stat.write_permit_latch = 1'b1; // see RULE_16
            end
            if (cs_rise && q.byte_cnt >= BYTE_ADDR && q.opcode == OPC_WR_DIS) begin
               d.stat.write_permit_latch = 1'b0; // see RULE_16
            end
            if (cs_rise && q.byte_cnt >= BYTE_ROW_DONE) begin
               if (q.opcode == OPC_PAGE_READ) begin
                  d.stat.ecc_result_field = ECC_NONE; // see RULE_08
                  d.stat.operation_busy_flag = 1'b1; // see RULE_17
                  d.cmd.req = 1'b1;
                  d.st = ST_RUN;
               end else if (q.opcode == OPC_PROG_EXEC && q.stat.write_permit_latch) begin // see RULE_15
                  d.stat.pfail = 1'b0; // see RULE_12
                  if (I_ROW_PROTECTED) begin
                     d.stat.pfail = 1'b1; // see RULE_11, RULE_18
                     d.stat.write_permit_latch = 1'b0;
                  end else begin
                     d.stat.operation_busy_flag = 1'b1; // see RULE_17
                     d.cmd.req = 1'b1;
                     d.st = ST_RUN;
                  end
               end else if (q.opcode == OPC_BLOCK_ERASE && q.stat.write_permit_latch) begin // see RULE_19
                  d.stat.efail = 1'b0; // see RULE_14
                  if (I_ROW_PROTECTED) begin
                     d.stat.efail = 1'b1; // see RULE_13, RULE_18
                     d.stat.write_permit_latch = 1'b0;
                  end else begin
                     d.stat.operation_busy_flag = 1'b1; // see RULE_17
                     d.cmd.req = 1'b1;
                     d.st = ST_RUN;
                  end
               end
            end
         end
      endcase

      // reset command stops anything in flight and beats a same-cycle completion
      if (cs_rise && q.byte_cnt >= BYTE_ADDR && q.opcode == OPC_RESET) begin
         d.cmd.abort = 1'b1;
         d.cmd.req = 1'b0;
         d.st = ST_RESET;
         d.wait_cnt = RESET_CNT_W'(RESET_BUSY_CYCLES);
         d.stat.ecc_result_field = ECC_NONE; // see RULE_08
         d.stat.pfail = 1'b0; // see RULE_12
         d.stat.efail = 1'b0; // see RULE_14
         d.stat.operation_busy_flag = 1'b1; // see RULE_17
      end
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         q <= STATE_RST;
      end else begin
         q <= d;
      end
   end

   assign O_SO = q.so;
   assign O_SO_OE = q.so_oe;
   assign O_ARRAY_CMD = q.cmd;
   assign O_STATUS = q.stat; // see RULE_20
   assign O_DRIVE_STRENGTH = q.drive;

   // ---- assertions ----
   localparam int RST_WAIT_MAX = RESET_BUSY_CYCLES + 2;

   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);

   sequence frame_end_s(logic [7:0] opc, logic [2:0] nbytes);
      cs_rise && q.opcode == opc && q.byte_cnt >= nbytes;
   endsequence

   sequence read_done_s;
      q.st == ST_RUN && q.cmd.op == ARR_READ && I_ARRAY_RESULT.done && !cs_rise;
   endsequence

   sequence op_done_s(array_op_t kind);
      q.st == ST_RUN && q.cmd.op == kind && I_ARRAY_RESULT.done && !cs_rise;
   endsequence

   // idle with the latch set, and the outside verdict on the row as given
   sequence armed_s(logic locked);
      q.st == ST_IDLE && q.stat.write_permit_latch && I_ROW_PROTECTED == locked;
   endsequence

   wel_set_a: assert property ( // see RULE_16
      frame_end_s(OPC_WR_EN, BYTE_ADDR) ##0 q.st == ST_IDLE |=> q.stat.write_permit_latch)
      else $error("write enable did not set the latch");
   wel_clear_a: assert property ( // see RULE_16
      frame_end_s(OPC_WR_DIS, BYTE_ADDR) ##0 q.st == ST_IDLE |=> !q.stat.write_permit_latch)
      else $error("write disable did not clear the latch");
   erase_ignored_a: assert property ( // see RULE_19
      frame_end_s(OPC_BLOCK_ERASE, BYTE_ROW_DONE) ##0 (q.st == ST_IDLE && !q.stat.write_permit_latch)
      |=> (!q.stat.operation_busy_flag && $stable(q.stat.efail) && !q.cmd.req))
      else $error("erase without write enable was not ignored");
   locked_erase_a: assert property ( // see RULE_18
      frame_end_s(OPC_BLOCK_ERASE, BYTE_ROW_DONE) ##0 armed_s(1'b1)
      |=> (q.stat.efail && !q.stat.operation_busy_flag)[*2])
      else $error("locked erase did not fail with busy low");
   erase_start_a: assert property ( // see RULE_14
      frame_end_s(OPC_BLOCK_ERASE, BYTE_ROW_DONE) ##0 armed_s(1'b0)
      |=> !q.stat.efail && q.stat.operation_busy_flag && q.cmd.req)
      else $error("erase start did not clear failure and raise busy");
   erase_fail_a: assert property ( // see RULE_13
      op_done_s(ARR_ERASE) |=> q.stat.efail == $past(I_ARRAY_RESULT.fail) && !q.stat.operation_busy_flag)
      else $error("erase result not reported");
   locked_prog_a: assert property ( // see RULE_11
      frame_end_s(OPC_PROG_EXEC, BYTE_ROW_DONE) ##0 armed_s(1'b1)
      |=> q.stat.pfail && !q.stat.operation_busy_flag)
      else $error("protected program did not set program failure");
   prog_start_a: assert property ( // see RULE_12
      frame_end_s(OPC_PROG_EXEC, BYTE_ROW_DONE) ##0 armed_s(1'b0)
      |=> (!q.stat.pfail && q.stat.operation_busy_flag && q.cmd.req) ##1 !q.cmd.req)
      else $error("program start did not clear failure and raise busy");
   prog_fail_a: assert property ( // see RULE_10
      op_done_s(ARR_PROG) |=> q.stat.pfail == $past(I_ARRAY_RESULT.fail) && !q.stat.write_permit_latch)
      else $error("program result not reported");
   read_start_a: assert property ( // see RULE_08
      frame_end_s(OPC_PAGE_READ, BYTE_ROW_DONE) ##0 q.st == ST_IDLE
      |=> q.stat.ecc_result_field == ECC_NONE && q.stat.operation_busy_flag)
      else $error("page read did not clear ecc result and raise busy");
   ecc_clean_a: assert property ( // see RULE_03
      read_done_s ##0 (!I_ARRAY_RESULT.ecc.uncorr && I_ARRAY_RESULT.ecc.err_count == 4'h0)
      |=> q.stat.ecc_result_field[1:0] == 2'b00)
      else $error("clean read misreported");
   ecc_upto4_a: assert property ( // see RULE_04
      read_done_s ##0 (!I_ARRAY_RESULT.ecc.uncorr && I_ARRAY_RESULT.ecc.err_count inside {[4'h1:ECC_LOW_LIMIT]})
      |=> q.stat.ecc_result_field == ECC_UPTO4)
      else $error("four or fewer corrected errors misreported");
   ecc_uncorr_a: assert property ( // see RULE_05
      read_done_s ##0 I_ARRAY_RESULT.ecc.uncorr
      |=> q.stat.ecc_result_field[1:0] == 2'b10 && !q.stat.operation_busy_flag)
      else $error("uncorrectable read not reported");
   ecc_limit_a: assert property ( // see RULE_06
      read_done_s ##0 (!I_ARRAY_RESULT.ecc.uncorr && I_ARRAY_RESULT.ecc.err_count == ECC_CAPABILITY)
      |=> q.stat.ecc_result_field == ECC_AT_LIMIT)
      else $error("at-capability read not reported");
   ecc_six_a: assert property ( // see RULE_04
      read_done_s ##0 (!I_ARRAY_RESULT.ecc.uncorr && I_ARRAY_RESULT.ecc.err_count == 4'h6)
      |=> q.stat.ecc_result_field == ECC_SIX)
      else $error("six corrected errors misreported");
   reset_cmd_a: assert property ( // see RULE_17
      frame_end_s(OPC_RESET, BYTE_ADDR) |=> (q.stat.operation_busy_flag && q.stat.ecc_result_field == ECC_NONE
         && !q.stat.pfail && !q.stat.efail)[*8])
      else $error("reset command did not clear flags and hold busy");
   reset_len_a: assert property ( // see RULE_17
      frame_end_s(OPC_RESET, BYTE_ADDR) |=> ##[1:RST_WAIT_MAX] !q.stat.operation_busy_flag)
      else $error("reset busy did not end in time");
   abort_pulse_a: assert property ( // see RULE_17
      frame_end_s(OPC_RESET, BYTE_ADDR) |=> q.cmd.abort && !q.cmd.req ##1 !q.cmd.abort)
      else $error("reset command did not stop the array with one abort pulse");
   boot_done_a: assert property ( // see RULE_09
      q.st == ST_BOOT && q.issued && I_ARRAY_RESULT.done && !cs_rise
      |=> !q.stat.operation_busy_flag && q.stat.ecc_result_field == $past(ecc_code))
      else $error("boot read result not loaded");
   // a completion or the end of reset busy in the same cycle may legally move the state
   poll_busy_a: assert property ( // see RULE_21
      q.stat.operation_busy_flag && !cs_n_lvl && sck_rise && q.bit_cnt == 3'h7 && q.byte_cnt == BYTE_ADDR
      && q.opcode == OPC_GET_FEAT && {q.shreg[6:0], si_lvl} == ADDR_OPERATION_STATUS && !I_ARRAY_RESULT.done
      && !(q.st == ST_RESET && q.wait_cnt == '0) |=> q.tx == $past(q.stat) && q.st == $past(q.st))
      else $error("status poll while busy not served");
endmodule // nand_status_register

/* File: spi_host_model.sv */
// Purpose: serial host that clocks feature and command frames into the block
// Assumes: mode 0, 160 ns serial clock, clock stands still between frames
// Notes: reply bits are taken on the rising serial edge, when they have settled
module spi_host_model (
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si,
   input wire logic i_so,
   input wire logic i_so_oe
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
   end

   // whole bytes only, msb first; a released data line reads as unknown
   task automatic xfer(input logic [31:0] w, input int n, output logic [7:0] r);
      r = 8'h00;
      o_cs_n = 1'b0;
      #80;
      for (int i = 0; i < n * 8; i++) begin
         o_si = w[31-i];
         #80 o_sck = 1'b1;
         if (i >= 16) begin
            r = {r[6:0], i_so_oe ? i_so : 1'bx};
         end
         #80 o_sck = 1'b0;
      end
      #40 o_cs_n = 1'b1;
      // data line is not held after the frame
      o_si = ~o_si;
   endtask
endmodule // spi_host_model

/* File: nand_status_register_tb_top.sv */
// Purpose: directed bench for the status and drive-strength feature registers
// Assumes: the bench answers array requests in place of the array engine
// Notes: expectations are status bytes {ecc, pfail, efail, latch, busy}
module nand_status_register_tb_top
   import nand_status_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk, rst, sck, cs_n, si, so, so_oe, prot, ok;
   logic [7:0] drv, r;
   array_result_t res;
   array_cmd_t cmd;
   status_t st;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [7:0] aborts = 8'h00;
   logic [3:0] cn [7] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
   logic [3:0] ex [7] = '{4'h0, 4'h1, 4'h5, 4'h9, 4'hd, 4'h3, 4'h2};

   nand_status_register i_dut (.I_SYS_CLK(clk), .I_RST(rst), .I_SCK(sck), .I_CS_N(cs_n), .I_SI(si),
      .O_SO(so), .O_SO_OE(so_oe), .I_ARRAY_RESULT(res), .I_ROW_PROTECTED(prot), .O_ARRAY_CMD(cmd),
      .O_STATUS(st), .O_DRIVE_STRENGTH(drv));
   spi_host_model i_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic end_sim;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cmd.abort === 1'b1) aborts++;
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tend(string s);
      $display("test %s ended, miscompares %0d", s, miscompares);
   endtask
   task automatic wait_req(output logic k);
      k = 1'b0;
      for (int i = 0; i < 40 && !k; i++) begin
         tick(1);
         if (cmd.req === 1'b1) k = 1'b1;
      end
   endtask
   task automatic fr(logic [31:0] w, int n);
      i_host.xfer(w, n, r);
      tick(8);
   endtask
   task automatic rd(logic [7:0] a);
      i_host.xfer({OPC_GET_FEAT, a, 16'h0000}, 3, r);
      tick(8);
   endtask
   task automatic op(logic [7:0] o, output logic k);
      i_host.xfer({o, 24'h001234}, 4, r);
      wait_req(k);
   endtask
   // engine answer: one-cycle done with the outcome beside it
   task automatic done(logic f, logic [3:0] c, logic u);
      res = '{1'b1, f, '{c, u}};
      tick(1);
      res = '0;
      tick(1);
   endtask

   initial begin
      res = '0;
      prot = 1'b0;
      rst = 1'b1;
      tick(10);
      rst = 1'b0;
      wait_req(ok);
      chk("boot req", 8'h01, {7'h00, ok});
      chk("boot busy", 8'h01, st);
      done(1'b0, 4'h5, 1'b0);
      chk("boot ecc", 8'h50, st);
      rd(ADDR_OPERATION_STATUS);
      chk("serial status", 8'h50, r);
      tend("boot");
      fr({OPC_SET_FEAT, ADDR_OUTPUT_DRIVE, 8'h5a, 8'h00}, 3);
      chk("drive port", 8'h5a, drv);
      rd(ADDR_OUTPUT_DRIVE);
      chk("drive read", 8'h5a, r);
      tend("drive");
      for (int i = 0; i < 7; i++) begin
         op(OPC_PAGE_READ, ok);
         chk("read req", 8'h01, {7'h00, ok});
         chk("read op", {6'h00, ARR_READ}, {6'h00, cmd.op});
         chk("read row", 8'h12, cmd.row[15:8]);
         chk("read start", 8'h01, st);
         done(1'b0, cn[i], i == 6);
         chk("ecc code", {ex[i], 4'h0}, st);
         if (ex[i] == ECC_AT_LIMIT) begin
            fr({OPC_WR_EN, 24'h0}, 1);
            op(OPC_PROG_EXEC, ok);
            done(1'b0, 4'h0, 1'b0);
            chk("refresh", 8'h30, st);
         end
      end
      tend("ecc");
      fr({OPC_WR_EN, 24'h0}, 1);
      chk("latch set", 8'h22, st);
      fr({OPC_WR_DIS, 24'h0}, 1);
      chk("latch clear", 8'h20, st);
      op(OPC_BLOCK_ERASE, ok);
      chk("erase ignored", 8'h20, {st[7:1], ok});
      tend("latch");
      for (int i = 0; i < 2; i++) begin
         fr({OPC_WR_EN, 24'h0}, 1);
         chk("latch before prog", i == 0 ? 8'h22 : 8'h2a, st);
         op(OPC_PROG_EXEC, ok);
         chk("prog run", 8'h23, st);
         done(i == 0, 4'h0, 1'b0);
         chk("prog end", i == 0 ? 8'h28 : 8'h20, st);
      end
      prot = 1'b1;
      fr({OPC_WR_EN, 24'h0}, 1);
      op(OPC_BLOCK_ERASE, ok);
      chk("locked erase", 8'h24, {st[7:1], ok});
      fr({OPC_WR_EN, 24'h0}, 1);
      op(OPC_PROG_EXEC, ok);
      chk("locked prog", 8'h2c, {st[7:1], ok});
      prot = 1'b0;
      fr({OPC_WR_EN, 24'h0}, 1);
      op(OPC_BLOCK_ERASE, ok);
      chk("erase run", 8'h2b, st);
      done(1'b1, 4'h0, 1'b0);
      chk("erase fail", 8'h2c, st);
      tend("prog erase");
      fr({OPC_RESET, 24'h0}, 1);
      chk("reset clears", 8'h01, st);
      chk("abort pulse", 8'h01, aborts);
      rd(ADDR_OPERATION_STATUS);
      chk("poll busy", 8'h01, r);
      for (int i = 0; i < 300 && st[0] !== 1'b0; i++) tick(1);
      chk("reset end", 8'h00, st);
      tend("reset");
      end_sim();
   end
endmodule // nand_status_register_tb_top
